// ===== inc/nvma_pkg.sv
package nvma_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] UNLOCK_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [7:0] ADDR_OFS = 8'h0c;
  localparam logic [7:0] TPTR_TOP_OFS = 8'h10;
  localparam logic [7:0] FLAGS_OFS = 8'h28;
  localparam int PLAIN_N = 6;
  // pointer high, pointer low, latch, global int, priority 2, enables 2
  localparam logic [7:0] PLAIN_OFS [PLAIN_N] = '{
    8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h2c
  };
  localparam int TPTR_HIGH_IDX = 0;
  localparam int TPTR_LOW_IDX = 1;
  localparam int TPTR_TOP_W = 6;

  // control register fields and flags done bit
  localparam int SEL_PROG_BIT = 7;
  localparam int SEL_CFG_BIT = 6;
  localparam int ROW_ERASE_BIT = 4;
  localparam int ABORT_BIT = 3;
  localparam int UNLOCK_BIT = 2;
  localparam int WGO_BIT = 1;
  localparam int RGO_BIT = 0;
  localparam int DONE_FLAG_BIT = 4;

  // unlock sequence values
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // reset and erased-byte values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // self-timed programming
  localparam int CLK_PERIOD_NS = 40;
  localparam int ERASE_TIME_NS = 2000;
  localparam int PROG_TIME_NS = 2000;
  localparam int ERASE_CYCLES =
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 16;
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic sel_prog;
    logic sel_cfg;
    logic rsv;
    logic row_erase;
    logic abort;
    logic unlock;
    logic wgo;
    logic rgo;
  } nvma_ctrl_t;

  typedef enum logic [1:0] {
    TGT_EEPROM,
    TGT_FLASH,
    TGT_CONFIG
  } nvma_target_t;

  typedef enum {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} nvma_key_t;
  typedef enum {OP_IDLE, OP_ERASE, OP_PROG} nvma_op_t;
endpackage

// ===== logic/nvma_byte_reg.sv
`timescale 1ns/1ns
module nvma_byte_reg #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic we,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] q
);
  // plain storage register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce && we) begin
      q <= wdata;
    end
  end
endmodule

// ===== logic/nvma_top.sv
// Summary of operation
// RULE1: space bit one selects program flash, zero selects data eeprom.
// RULE2: config bit one targets configuration space, else space bit decides.
// RULE3: write unlock bit permits writes; cleared at power-up.
// RULE4: abort flag set as unlocked write starts, cleared at timer expiry.
// RULE5: abort flag reads one after reset-cut or improper write.
// RULE6: select bits keep their values through an abort.
// RULE7: write-go starts self-timed op; software sets, hardware clears.
// RULE8: completion sets done flag; it stays until software clears it.
// RULE9: read-go reads eeprom in one cycle, then clears itself.
// RULE10: read-go refused while flash or config space selected.
// RULE11: row erase bit makes write-go erase a row; completion clears it.
// RULE12: unlock port stores nothing and reads as zero.
// RULE13: eeprom byte write erases first then programs, timer-controlled.
// RULE14: eeprom accessed a byte at a time via data and address.
// RULE15: firmware unlocks before every flash write too.
// RULE16: table pointer is 22 bits in three bytes; bit 21 is config.
// RULE17: write starts only after 55h, 0aah, then write-go.
// RULE18: write-go refused unless unlock was set beforehand.
// RULE19: control, address and data ignore writes while busy.
// RULE20: parameterised cycle timer ends op, clears go and abort.
`timescale 1ns/1ns
module nvma_top #(
  parameter int DEPTH = 256,
  parameter int ERASE_CYC = nvma_pkg::ERASE_CYCLES,
  parameter int PROG_CYC = nvma_pkg::PROG_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic ext_warm_rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic op_active,
  output logic [1:0] op_target,
  output logic op_erase,
  output logic nvm_done_flag,
  output logic [21:0] table_pointer
);
  ////////////////////////////////////////////////////////////////////////
  // declarations
  nvma_pkg::nvma_ctrl_t ctrl_r;
  nvma_pkg::nvma_key_t key_r;
  nvma_pkg::nvma_op_t op_r;
  logic [7:0] data_r;
  logic [7:0] addr_r;
  logic [7:0] flags_r;
  logic [7:0] mem [DEPTH];
  logic [nvma_pkg::TMR_W-1:0] tmr_r;
  logic [nvma_pkg::SYNC_STAGES-1:0] wr_sync_r;
  logic [7:0] plain_q [nvma_pkg::PLAIN_N];
  logic [nvma_pkg::TPTR_TOP_W-1:0] tptr_top;
  logic wr_fire;
  logic rd_take;
  logic [7:0] wbyte;
  logic busy;
  logic warm_hit;
  logic tmr_end;
  logic op_done;
  logic ctrl_we;
  logic start_ok;
  logic [31:0] rdata_nxt;
  logic map_hit;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  assign wr_fire = psel && penable && pready && pwrite && !pslverr;
  assign rd_take = psel && penable && !pready;
  assign wbyte = pwdata[7:0];
  assign busy = ctrl_r.wgo;
  assign tmr_end = (op_r != nvma_pkg::OP_IDLE) && (tmr_r == '0);
  assign op_done = tmr_end && (op_r == nvma_pkg::OP_PROG ||
    !(op_target == nvma_pkg::TGT_EEPROM));
  // RULE19: locked while busy
  assign ctrl_we = wr_fire && (paddr == nvma_pkg::CTRL_OFS) && !busy;
  // RULE17: full key sequence needed
  // RULE18: unlock from an earlier write
  assign start_ok = ctrl_we && wbyte[nvma_pkg::WGO_BIT] &&
    ctrl_r.unlock && (key_r == nvma_pkg::KEY_ARMED);

  ////////////////////////////////////////////////////////////////////////
  // warm reset pin synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_sync_r <= '1;
    end else if (ce) begin
      wr_sync_r <= {wr_sync_r[1:0], ext_warm_rst_n};
    end
  end
  assign warm_hit = !wr_sync_r[1] && !wr_sync_r[2];

  ////////////////////////////////////////////////////////////////////////
  // unlock key sequence
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_r <= nvma_pkg::KEY_IDLE;
    end else if (ce) begin
      if (warm_hit) begin
        key_r <= nvma_pkg::KEY_IDLE;
      end else if (wr_fire && paddr == nvma_pkg::UNLOCK_OFS) begin
        // RULE17: ordered key values
        case (key_r)
          nvma_pkg::KEY_IDLE: begin
            key_r <= (wbyte == nvma_pkg::KEY_FIRST) ?
              nvma_pkg::KEY_GOT_FIRST : nvma_pkg::KEY_IDLE;
          end
          nvma_pkg::KEY_GOT_FIRST: begin
            key_r <= (wbyte == nvma_pkg::KEY_SECOND) ?
              nvma_pkg::KEY_ARMED : nvma_pkg::KEY_IDLE;
          end
          default: begin
            key_r <= nvma_pkg::KEY_IDLE;
          end
        endcase
      end else if (wr_fire) begin
        key_r <= nvma_pkg::KEY_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // RULE3: unlock clear at power-up
      ctrl_r <= '0;
    end else if (ce) begin
      if (warm_hit) begin
        // RULE5: cut-short write leaves abort set
        // RULE6: selects kept for tracing
        ctrl_r.wgo <= 1'b0;
        ctrl_r.rgo <= 1'b0;
      end else if (ctrl_we) begin
        ctrl_r.sel_prog <= wbyte[nvma_pkg::SEL_PROG_BIT];
        ctrl_r.sel_cfg <= wbyte[nvma_pkg::SEL_CFG_BIT];
        ctrl_r.row_erase <= wbyte[nvma_pkg::ROW_ERASE_BIT];
        ctrl_r.unlock <= wbyte[nvma_pkg::UNLOCK_BIT];
        // RULE7: go bit only set here
        ctrl_r.wgo <= start_ok;
        // RULE4: abort raised at start
        // RULE5: improper attempt sets abort
        ctrl_r.abort <= wbyte[nvma_pkg::ABORT_BIT] ||
          wbyte[nvma_pkg::WGO_BIT];
        // RULE10: refused outside eeprom space
        ctrl_r.rgo <= wbyte[nvma_pkg::RGO_BIT] &&
          !wbyte[nvma_pkg::SEL_PROG_BIT] && !wbyte[nvma_pkg::SEL_CFG_BIT];
      end else begin
        // RULE9: read lasts one cycle
        ctrl_r.rgo <= 1'b0;
        if (op_done) begin
          // RULE20: expiry clears go and abort
          ctrl_r.wgo <= 1'b0;
          ctrl_r.abort <= 1'b0;
          // RULE11: erase completion clears row erase
          if (op_erase) begin
            ctrl_r.row_erase <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // self-timed operation sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_r <= nvma_pkg::OP_IDLE;
      tmr_r <= '0;
      op_active <= 1'b0;
      op_target <= nvma_pkg::TGT_EEPROM;
      op_erase <= 1'b0;
    end else if (ce) begin
      if (warm_hit) begin
        op_r <= nvma_pkg::OP_IDLE;
        op_active <= 1'b0;
        op_erase <= 1'b0;
      end else begin
        case (op_r)
          nvma_pkg::OP_IDLE: begin
            if (start_ok) begin
              op_active <= 1'b1;
              // RULE2: config space wins
              // RULE1: space bit picks flash or eeprom
              if (wbyte[nvma_pkg::SEL_CFG_BIT]) begin
                op_target <= nvma_pkg::TGT_CONFIG;
              end else if (wbyte[nvma_pkg::SEL_PROG_BIT]) begin
                op_target <= nvma_pkg::TGT_FLASH;
              end else begin
                op_target <= nvma_pkg::TGT_EEPROM;
              end
              // RULE13: eeprom always erases first
              // RULE11: flash row erase on request
              if (!wbyte[nvma_pkg::SEL_CFG_BIT] &&
                  (!wbyte[nvma_pkg::SEL_PROG_BIT] ||
                   wbyte[nvma_pkg::ROW_ERASE_BIT])) begin
                op_r <= nvma_pkg::OP_ERASE;
                op_erase <= 1'b1;
                tmr_r <= nvma_pkg::TMR_W'(ERASE_CYC - 1);
              end else begin
                op_r <= nvma_pkg::OP_PROG;
                op_erase <= 1'b0;
                tmr_r <= nvma_pkg::TMR_W'(PROG_CYC - 1);
              end
            end
          end
          nvma_pkg::OP_ERASE: begin
            // RULE20: cycle timer
            if (tmr_r != '0) begin
              tmr_r <= tmr_r - 1'b1;
            end else if (op_target == nvma_pkg::TGT_EEPROM) begin
              op_r <= nvma_pkg::OP_PROG;
              op_erase <= 1'b0;
              tmr_r <= nvma_pkg::TMR_W'(PROG_CYC - 1);
            end else begin
              op_r <= nvma_pkg::OP_IDLE;
              op_active <= 1'b0;
              op_erase <= 1'b0;
            end
          end
          nvma_pkg::OP_PROG: begin
            if (tmr_r != '0) begin
              tmr_r <= tmr_r - 1'b1;
            end else begin
              op_r <= nvma_pkg::OP_IDLE;
              op_active <= 1'b0;
            end
          end
          default: begin
            op_r <= nvma_pkg::OP_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // eeprom array, byte wide
  always_ff @(posedge ref_clk) begin
    if (ce && !warm_hit && tmr_end && op_target == nvma_pkg::TGT_EEPROM) begin
      // RULE13: erase then program
      if (op_r == nvma_pkg::OP_ERASE) begin
        mem[addr_r] <= nvma_pkg::ERASED_BYTE;
      end else begin
        mem[addr_r] <= data_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data and address registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= nvma_pkg::BYTE_RST;
      addr_r <= nvma_pkg::BYTE_RST;
    end else if (ce) begin
      // RULE14: byte access
      if (ctrl_r.rgo) begin
        // RULE9: one-cycle read
        data_r <= mem[addr_r];
      end else if (wr_fire && !busy && paddr == nvma_pkg::DATA_OFS) begin
        data_r <= wbyte;
      end
      // RULE19: address locked while busy
      if (wr_fire && !busy && paddr == nvma_pkg::ADDR_OFS) begin
        addr_r <= wbyte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags register with completion flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= nvma_pkg::BYTE_RST;
    end else if (ce) begin
      if (wr_fire && paddr == nvma_pkg::FLAGS_OFS) begin
        flags_r <= wbyte;
      end
      // RULE8: set wins over clear
      if (op_done && !warm_hit) begin
        flags_r[nvma_pkg::DONE_FLAG_BIT] <= 1'b1;
      end
    end
  end
  assign nvm_done_flag = flags_r[nvma_pkg::DONE_FLAG_BIT];

  ////////////////////////////////////////////////////////////////////////
  // plain registers and table pointer
  for (genvar i = 0; i < nvma_pkg::PLAIN_N; i++) begin : g_plain
    nvma_byte_reg #(.WIDTH(8)) u_reg (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .ce(ce),
      .we(wr_fire && paddr == nvma_pkg::PLAIN_OFS[i]),
      .wdata(wbyte),
      .q(plain_q[i])
    );
  end
  // RULE16: 22-bit pointer, top bit config
  nvma_byte_reg #(.WIDTH(nvma_pkg::TPTR_TOP_W)) u_tptr_top (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .we(wr_fire && paddr == nvma_pkg::TPTR_TOP_OFS),
    .wdata(wbyte[nvma_pkg::TPTR_TOP_W-1:0]),
    .q(tptr_top)
  );
  assign table_pointer = {tptr_top, plain_q[nvma_pkg::TPTR_HIGH_IDX],
    plain_q[nvma_pkg::TPTR_LOW_IDX]};

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rdata_nxt = '0;
    map_hit = 1'b1;
    case (paddr)
      nvma_pkg::CTRL_OFS: rdata_nxt[7:0] = {ctrl_r[7:6], 1'b0, ctrl_r[4:0]};
      // RULE12: unlock port reads zero
      nvma_pkg::UNLOCK_OFS: rdata_nxt = '0;
      nvma_pkg::DATA_OFS: rdata_nxt[7:0] = data_r;
      nvma_pkg::ADDR_OFS: rdata_nxt[7:0] = addr_r;
      nvma_pkg::TPTR_TOP_OFS: rdata_nxt[5:0] = tptr_top;
      nvma_pkg::FLAGS_OFS: rdata_nxt[7:0] = flags_r;
      default: begin
        map_hit = 1'b0;
        for (int k = 0; k < nvma_pkg::PLAIN_N; k++) begin
          if (paddr == nvma_pkg::PLAIN_OFS[k]) begin
            rdata_nxt[7:0] = plain_q[k];
            map_hit = 1'b1;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // apb answer, one wait state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (ce) begin
      pready <= rd_take;
      if (rd_take) begin
        pslverr <= !map_hit;
        prdata <= pwrite ? '0 : rdata_nxt;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  rd_self_clear_a: assert property ( // RULE9
    ce && ctrl_r.rgo |=> !ctrl_r.rgo && data_r == $past(mem[addr_r]))
    else $error("read go did not clear after one cycle");
  rd_refused_a: assert property ( // RULE10
    $rose(ctrl_r.rgo) |-> !ctrl_r.sel_prog && !ctrl_r.sel_cfg)
    else $error("read started outside eeprom space");
  wgo_unlock_a: assert property ( // RULE18
    $rose(ctrl_r.wgo) |-> $past(ctrl_r.unlock) &&
      $past(key_r) == nvma_pkg::KEY_ARMED)
    else $error("write started without prior unlock and key");
  abort_on_start_a: assert property ( // RULE4
    $rose(ctrl_r.wgo) |-> ctrl_r.abort && op_active)
    else $error("abort flag not raised at write start");
  done_sets_flag_a: assert property ( // RULE8
    ce && op_done && !warm_hit |=>
      nvm_done_flag && !ctrl_r.wgo && !ctrl_r.abort)
    else $error("completion did not set done and clear go");
  warm_abort_a: assert property ( // RULE6
    ce && warm_hit && busy |=> ctrl_r.abort && !ctrl_r.wgo &&
      $stable(ctrl_r.sel_prog) && $stable(ctrl_r.sel_cfg))
    else $error("reset abort lost flag or selects");
  unlock_reads_zero_a: assert property ( // RULE12
    ce && rd_take && !pwrite && paddr == nvma_pkg::UNLOCK_OFS |=>
      prdata == '0)
    else $error("unlock port read nonzero");
  busy_lock_a: assert property ( // RULE19
    busy && $past(busy) |-> $stable(addr_r) && $stable(ctrl_r.unlock))
    else $error("registers changed during write");
  eeprom_prog_a: assert property ( // RULE13
    ce && !warm_hit && tmr_end && op_r == nvma_pkg::OP_ERASE &&
      op_target == nvma_pkg::TGT_EEPROM |=> op_r == nvma_pkg::OP_PROG &&
      mem[addr_r] == nvma_pkg::ERASED_BYTE)
    else $error("eeprom erase did not precede program");
endmodule

// ===== tb/nvma_fw_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// firmware side: apb master and write unlock sequence
module nvma_fw_model (
  input wire logic ref_clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  logic [31:0] rdat;
  logic rerr;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // key before each go
  task automatic start_op(input logic [7:0] c);
    wr(nvma_pkg::UNLOCK_OFS, nvma_pkg::KEY_FIRST);
    wr(nvma_pkg::UNLOCK_OFS, nvma_pkg::KEY_SECOND);
    wr(nvma_pkg::CTRL_OFS, c);
  endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_total++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module testbench;
  localparam int EC = 12;
  localparam int PC = 16;
  localparam logic [7:0] CT = nvma_pkg::CTRL_OFS;
  localparam logic [7:0] UL = nvma_pkg::UNLOCK_OFS;
  localparam logic [7:0] DT = nvma_pkg::DATA_OFS;
  logic ref_clk, rst_n, ce, ext_warm_rst_n;
  logic psel, penable, pwrite, pready, pslverr;
  logic op_active, op_erase, nvm_done_flag;
  logic [7:0] paddr, a, d, hi, lo;
  logic [31:0] pwdata, prdata;
  logic [1:0] op_target;
  logic [21:0] table_pointer;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int act = 0;
  int mem[int];
  nvma_top #(.DEPTH(256), .ERASE_CYC(EC), .PROG_CYC(PC)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .ext_warm_rst_n(ext_warm_rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_active(op_active),
    .op_target(op_target), .op_erase(op_erase),
    .nvm_done_flag(nvm_done_flag), .table_pointer(table_pointer)
  );
  nvma_fw_model fw (
    .ref_clk(ref_clk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata)
  );
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // cycle count, busy count, hang limit
  always @(posedge ref_clk) begin
    cyc++;
    if (op_active === 1'b1) act++;
    if (cyc > 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] o,
                       input logic [31:0] e);
    fw.rd(o);
    `CHK(nm, e, fw.rdat)
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge ref_clk);
      #1;
      if (op_active === 1'b0) break;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // unlocked op: target, erase phase, busy view, length, end state
  task automatic run_op(input logic [7:0] pre, go, input logic [1:0] tg,
                        input logic er, input int n, input logic [31:0] post);
    fw.wr(nvma_pkg::FLAGS_OFS, 8'h00);
    fw.wr(CT, pre);
    act = 0;
    fw.start_op(go);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("target", tg, op_target)
    `CHK("erase", er, op_erase)
    rdchk("busy", CT, {24'h0, go | 8'h08});
    fw.wr(DT, ~d);
    wait_idle();
    `CHK("cycles", n, act)
    `CHK("done", 1'b1, nvm_done_flag)
    rdchk("ctrl", CT, post);
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    ext_warm_rst_n = 1'b1;
    void'($urandom(59));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    fw.wr(UL, nvma_pkg::KEY_FIRST);
    rdchk("unlock", UL, 32'h0);
    fw.rd(8'h30);
    `CHK("slverr", 1'b1, fw.rerr)
    for (int i = 0; i < nvma_pkg::PLAIN_N; i++) begin
      d = 8'($urandom);
      fw.wr(nvma_pkg::PLAIN_OFS[i], d);
      rdchk("plain", nvma_pkg::PLAIN_OFS[i], {24'h0, d});
    end
    hi = 8'($urandom);
    lo = 8'($urandom);
    fw.wr(nvma_pkg::PLAIN_OFS[nvma_pkg::TPTR_HIGH_IDX], hi);
    fw.wr(nvma_pkg::PLAIN_OFS[nvma_pkg::TPTR_LOW_IDX], lo);
    fw.wr(nvma_pkg::TPTR_TOP_OFS, 8'hff);
    rdchk("top", nvma_pkg::TPTR_TOP_OFS, 32'h3f);
    `CHK("tptr", {6'h3f, hi, lo}, table_pointer)
    a = 8'($urandom);
    d = 8'($urandom);
    mem[a] = d;
    fw.wr(nvma_pkg::ADDR_OFS, a);
    fw.wr(DT, d);
    run_op(8'h04, 8'h06, 2'd0, 1'b1, EC + PC, 32'h04);
    fw.wr(DT, ~d);
    fw.wr(CT, 8'h05);
    rdchk("rdata", DT, mem[a]);
    rdchk("rgo", CT, 32'h04);
    rdchk("flags", nvma_pkg::FLAGS_OFS, 32'h10);
    fw.wr(nvma_pkg::FLAGS_OFS, 8'h00);
    #1;
    `CHK("clear", 1'b0, nvm_done_flag)
    for (int k = 0; k < 3; k++) begin
      fw.wr(CT, k == 2 ? 8'h04 : 8'h00);
      if (k > 0) fw.wr(UL, nvma_pkg::KEY_FIRST);
      if (k == 2) fw.wr(DT, d);
      if (k > 0) fw.wr(UL, nvma_pkg::KEY_SECOND);
      fw.wr(CT, 8'h06);
      rdchk("improper", CT, 32'h0c);
      `CHK("nostart", 1'b0, op_active)
    end
    fw.wr(DT, ~d);
    fw.wr(CT, 8'h85);
    rdchk("rgo_prog", CT, 32'h84);
    fw.wr(CT, 8'h45);
    rdchk("rgo_cfg", CT, 32'h44);
    rdchk("kept", DT, {24'h0, ~d});
    run_op(8'h94, 8'h96, 2'd1, 1'b1, EC, 32'h84);
    run_op(8'h84, 8'h86, 2'd1, 1'b0, PC, 32'h84);
    run_op(8'h44, 8'h46, 2'd2, 1'b0, PC, 32'h44);
    fw.wr(CT, 8'h84);
    act = 0;
    fw.start_op(8'h86);
    ce <= 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    `CHK("frozen", 1'b1, op_active)
    ce <= 1'b1;
    wait_idle();
    `CHK("frozen_len", PC + 20, act)
    fw.wr(CT, 8'h84);
    fw.start_op(8'h86);
    ext_warm_rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    ext_warm_rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK("cut", 1'b0, op_active)
    rdchk("trace", CT, 32'h8c);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk("por", CT, 32'h00);
    close_out();
  end
endmodule
